//--- src/ccbc_pkg.sv
// constants and carrier types for the contactless card command sequencer (reader side)
package ccbc_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 20;
    // authentication answer limit, both parts
    localparam int AUTH_TIMEOUT_US = 1000;
    // read, write part 1, value parts, set answer limit
    localparam int SHORT_TIMEOUT_US = 5000;
    // write part 2 and transfer answer limit
    localparam int LONG_TIMEOUT_US = 10000;
    // frame delay for n=9: (9*128+20)/13.56 MHz
    localparam int FDT_MIN_NS = 86430;
    // longest times round down, least times round up
    localparam int AUTH_TIMEOUT_CYC = AUTH_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int SHORT_TIMEOUT_CYC = SHORT_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int LONG_TIMEOUT_CYC = LONG_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int FDT_MIN_CYC = (FDT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 20;

    // ==========================================================
    // opcodes and answer codes
    localparam logic [7:0] OP_AUTH_A = 8'h60;
    localparam logic [7:0] OP_AUTH_B = 8'h61;
    localparam logic [7:0] OP_READ = 8'h30;
    localparam logic [7:0] OP_WRITE = 8'ha0;
    localparam logic [7:0] OP_DEC = 8'hc0;
    localparam logic [7:0] OP_INC = 8'hc1;
    localparam logic [7:0] OP_RESTORE = 8'hc2;
    localparam logic [7:0] OP_TRANSFER = 8'hb0;
    localparam logic [3:0] ACK_CODE = 4'ha;

    // ==========================================================
    // frame lengths in bytes
    localparam int CNT_W = 5;
    localparam logic [4:0] HDR_BYTES = 5'h02;
    localparam logic [4:0] CHALLENGE_BYTES = 5'h04;
    localparam logic [4:0] READER_REPLY_BYTES = 5'h08;
    localparam logic [4:0] BLOCK_BYTES = 5'h10;
    localparam logic [4:0] OPERAND_BYTES = 5'h04;
    localparam logic [4:0] NO_BYTES = 5'h00;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SEND1 = 3'h1,
        ST_WAIT1 = 3'h3,
        ST_GAP = 3'h2,
        ST_SEND2 = 3'h6,
        ST_WAIT2 = 3'h7
    } ccbc_state_t;

    typedef enum logic [2:0] {
        RES_OK = 3'h0,
        RES_NAK = 3'h1,
        RES_TIMEOUT = 3'h2,
        RES_EARLY = 3'h3,
        RES_LENGTH = 3'h4
    } ccbc_res_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] addr;
        logic [127:0] payload;
    } ccbc_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } ccbc_tx_t;

    typedef struct packed {
        logic [7:0] data;
        logic nibble;
        logic last;
    } ccbc_rx_t;

endpackage

//--- src/ccbc_reader.sv
// reader-side sequencer for the card's block memory commands
`timescale 1ns/100ps

// Contract
// - auth starts with 60h (first key) or 61h (second key), address, CRC.
// - auth part one answers 4 challenge bytes; reader sends 8; card returns 4.
// - each auth answer within 1 ms, never before n=9; silence means timeout.
// - reader leaves at least the minimum frame delay between auth parts.
// - every memory command sends a one-byte address right after the opcode.
// - read answer no earlier than n=9, timeout after 5 ms.
// - write A0h: part one opcode and address, after ACK part two 16 bytes.
// - write answers within 5 ms and 10 ms, never before n=9.
// - reader leaves at least the minimum frame delay between write parts.
// - value operand is four signed bytes sent in part two.
// - value part two has no ACK; reader lets 5 ms timeout expire as success.
// - reader leaves at least the minimum frame delay between value parts.
// - value results stay in the buffer until a separate transfer.
// - reader's identity input to auth is the last cascade level identifier.
module ccbc_reader #(
    parameter int AUTH_TIMEOUT_CYC = ccbc_pkg::AUTH_TIMEOUT_CYC,
    parameter int SHORT_TIMEOUT_CYC = ccbc_pkg::SHORT_TIMEOUT_CYC,
    parameter int LONG_TIMEOUT_CYC = ccbc_pkg::LONG_TIMEOUT_CYC,
    parameter int FDT_MIN_CYC = ccbc_pkg::FDT_MIN_CYC
) (
    input wire logic i_clk_sys,                 // system clock, 50 MHz
    input wire logic i_srst,                    // synchronous reset, high
    input wire logic i_req_valid,               // command request
    input wire ccbc_pkg::ccbc_req_t i_req,      // opcode, address, payload
    output logic o_req_ready,                   // idle, request taken
    output logic o_tx_valid,                    // byte to send to the card
    output ccbc_pkg::ccbc_tx_t o_tx,            // byte and end of frame
    input wire logic i_tx_ready,                // framer takes the byte
    input wire logic i_rx_valid,                // frame item from the card
    input wire ccbc_pkg::ccbc_rx_t i_rx,        // byte or 4-bit code
    output logic o_done,                        // command finished, pulse
    output ccbc_pkg::ccbc_res_t o_result,       // outcome of the command
    output logic [127:0] o_rdata                // answer bytes
);
    localparam logic [19:0] LIM_AUTH = 20'(AUTH_TIMEOUT_CYC);
    localparam logic [19:0] LIM_SHORT = 20'(SHORT_TIMEOUT_CYC);
    localparam logic [19:0] LIM_LONG = 20'(LONG_TIMEOUT_CYC);
    localparam logic [19:0] LIM_EARLY = 20'(FDT_MIN_CYC);

    ccbc_pkg::ccbc_state_t st_q, st_d;
    ccbc_pkg::ccbc_req_t req_q;
    ccbc_pkg::ccbc_res_t res_q, res_d;
    logic [127:0] sh_q;
    logic [127:0] rdata_q;
    logic [4:0] cnt_q;
    logic [4:0] rcnt_q;
    logic [4:0] exp_bytes;
    logic [4:0] part2_len;
    logic [19:0] tmr_q;
    logic [19:0] lim;
    logic done_q, fin;
    logic is_auth, is_val, is_write, two_part;
    logic tx_fire, waiting, tmo, early, val_p2;

    // ==========================================================
    // command decode
    // both key selections are authentication
    assign is_auth = (req_q.opcode == ccbc_pkg::OP_AUTH_A) || (req_q.opcode == ccbc_pkg::OP_AUTH_B);
    // increment, decrement and restore share one sequence
    assign is_val = (req_q.opcode == ccbc_pkg::OP_INC) || (req_q.opcode == ccbc_pkg::OP_DEC)
        || (req_q.opcode == ccbc_pkg::OP_RESTORE);
    assign is_write = req_q.opcode == ccbc_pkg::OP_WRITE;
    // transfer is its own single-part command, never chained here
    assign two_part = is_auth || is_val || is_write;

    always_comb begin
        part2_len = ccbc_pkg::OPERAND_BYTES;
        if (is_auth) begin
            part2_len = ccbc_pkg::READER_REPLY_BYTES;
        end else if (is_write) begin
            part2_len = ccbc_pkg::BLOCK_BYTES;
        end
    end

    logic is_read;
    logic is_xfer;
    logic rx_byte;
    logic rx_last;
    logic ack_seen;
    logic cnt_ok;
    logic [19:0] tmr_d;
    logic [19:0] quiet_q;
    logic [127:0] sh_d;
    logic [127:0] pl_q;
    ccbc_pkg::ccbc_tx_t tx_q;

    assign is_read = req_q.opcode == ccbc_pkg::OP_READ;
    assign is_xfer = req_q.opcode == ccbc_pkg::OP_TRANSFER;
    assign waiting = (st_q == ccbc_pkg::ST_WAIT1) || (st_q == ccbc_pkg::ST_WAIT2);
    assign val_p2 = (st_q == ccbc_pkg::ST_WAIT2) && is_val;
    assign rx_byte = waiting && i_rx_valid && !i_rx.nibble;
    assign rx_last = waiting && i_rx_valid && i_rx.last;
    assign ack_seen = i_rx.nibble && (i_rx.data[3:0] == ccbc_pkg::ACK_CODE);
    assign cnt_ok = (exp_bytes != ccbc_pkg::NO_BYTES) && !i_rx.nibble
        && ((rcnt_q + 5'h01) == exp_bytes);
    assign tx_fire = o_tx_valid && i_tx_ready;

    // ==========================================================
    // answer limits and expected answer length
    always_comb begin
        lim = LIM_SHORT;
        exp_bytes = ccbc_pkg::NO_BYTES;
        if (is_auth) begin
            // both auth answers share the short auth limit
            lim = LIM_AUTH;
            exp_bytes = ccbc_pkg::CHALLENGE_BYTES;
        end else if (st_q == ccbc_pkg::ST_WAIT1) begin
            // a read answer is a whole block
            if (is_read) begin
                exp_bytes = ccbc_pkg::BLOCK_BYTES;
            end
            if (is_xfer) begin
                lim = LIM_LONG;
            end
        end else if (is_write) begin
            // write part two gets the long limit
            lim = LIM_LONG;
        end
    end

    // silence past the limit, or an answer too soon
    assign tmo = waiting && (rcnt_q == 5'h00) && !i_rx_valid && (tmr_q >= lim);
    assign early = waiting && i_rx_valid && (tmr_q < LIM_EARLY);

    // ==========================================================
    // sequencing
    always_comb begin
        st_d = st_q;
        res_d = res_q;
        fin = 1'b0;
        unique case (st_q)
            ccbc_pkg::ST_IDLE: begin
                if (i_req_valid) begin
                    st_d = ccbc_pkg::ST_SEND1;
                end
            end
            ccbc_pkg::ST_SEND1: begin
                if (tx_fire && o_tx.last) begin
                    st_d = ccbc_pkg::ST_WAIT1;
                end
            end
            ccbc_pkg::ST_WAIT1, ccbc_pkg::ST_WAIT2: begin
                if (early) begin
                    fin = 1'b1;
                    res_d = ccbc_pkg::RES_EARLY;
                end else if (tmo) begin
                    fin = 1'b1;
                    // value part two is never answered, silence is success
                    res_d = val_p2 ? ccbc_pkg::RES_OK : ccbc_pkg::RES_TIMEOUT;
                end else if (rx_last) begin
                    if (i_rx.nibble && !ack_seen) begin
                        fin = 1'b1;
                        res_d = ccbc_pkg::RES_NAK;
                    end else if (ack_seen ? (exp_bytes == ccbc_pkg::NO_BYTES) : cnt_ok) begin
                        // part two only after part one is answered
                        if ((st_q == ccbc_pkg::ST_WAIT1) && two_part) begin
                            st_d = ccbc_pkg::ST_GAP;
                        end else begin
                            fin = 1'b1;
                            res_d = ccbc_pkg::RES_OK;
                        end
                    end else begin
                        fin = 1'b1;
                        res_d = ccbc_pkg::RES_LENGTH;
                    end
                end
            end
            ccbc_pkg::ST_GAP: begin
                // hold off part two for the least frame delay
                if (tmr_q >= (LIM_EARLY - 20'h00001)) begin
                    st_d = ccbc_pkg::ST_SEND2;
                end
            end
            ccbc_pkg::ST_SEND2: begin
                if (tx_fire && o_tx.last) begin
                    st_d = ccbc_pkg::ST_WAIT2;
                end
            end
            default: begin
                st_d = ccbc_pkg::ST_IDLE;
            end
        endcase
        if (fin) begin
            st_d = ccbc_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            st_q <= ccbc_pkg::ST_IDLE;
            res_q <= ccbc_pkg::RES_OK;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            res_q <= res_d;
            done_q <= fin;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            req_q <= '0;
        end else if (o_req_ready && i_req_valid) begin
            req_q <= i_req;
        end
    end

    // ==========================================================
    // timer and counters, restarted on every state change
    always_comb begin
        tmr_d = tmr_q + 20'h00001;
        if ((st_d != st_q) || (st_q == ccbc_pkg::ST_IDLE)) begin
            tmr_d = '0;
        end else if (tmr_q == 20'hfffff) begin
            tmr_d = tmr_q;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || (st_d != st_q)) begin
            cnt_q <= '0;
            rcnt_q <= '0;
        end else begin
            if (tx_fire) begin
                cnt_q <= cnt_q + 5'h01;
            end
            if (rx_byte) begin
                rcnt_q <= rcnt_q + 5'h01;
            end
        end
    end

    // ==========================================================
    // transmit path: the byte on the link always comes from a flop
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            tx_q <= '0;
            pl_q <= '0;
        end else if (o_req_ready && i_req_valid) begin
            tx_q <= {i_req.opcode, 1'b0};
            // caller builds the reply from the last cascade identifier
            pl_q <= i_req.payload;
        end else if ((st_q == ccbc_pkg::ST_GAP) && (st_d == ccbc_pkg::ST_SEND2)) begin
            // part two bytes come from the top of the payload
            tx_q <= {pl_q[127:120], part2_len == 5'h01};
            pl_q <= {pl_q[119:0], 8'h00};
        end else if (tx_fire && (st_q == ccbc_pkg::ST_SEND1) && !o_tx.last) begin
            // address byte right after the opcode
            tx_q <= {req_q.addr, 1'b1};
        end else if (tx_fire && (st_q == ccbc_pkg::ST_SEND2)) begin
            tx_q <= {pl_q[127:120], (cnt_q + 5'h02) == part2_len};
            pl_q <= {pl_q[119:0], 8'h00};
        end
    end

    assign o_req_ready = st_q == ccbc_pkg::ST_IDLE;
    assign o_tx_valid = (st_q == ccbc_pkg::ST_SEND1) || (st_q == ccbc_pkg::ST_SEND2);
    assign o_tx = tx_q;

    // ==========================================================
    // receive path
    assign sh_d = rx_byte ? {sh_q[119:0], i_rx.data} : sh_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sh_q <= '0;
            rdata_q <= '0;
        end else begin
            sh_q <= o_req_ready ? '0 : sh_d;
            if (fin) begin
                rdata_q <= sh_d;
            end
        end
    end

    assign o_done = done_q;
    assign o_result = res_q;
    assign o_rdata = rdata_q;

    // ==========================================================
    // checks; quiet time counted apart from the sequencer's timer
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || i_rx_valid) begin
            quiet_q <= '0;
        end else if (quiet_q != 20'hfffff) begin
            quiet_q <= quiet_q + 20'h00001;
        end
    end

    sequence s_opcode_sent;
        tx_fire && (st_q == ccbc_pkg::ST_SEND1) && !o_tx.last;
    endsequence

    sequence s_value_silent;
        val_p2 && tmo;
    endsequence

    a_opcode_first: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        ((st_q == ccbc_pkg::ST_SEND1) && !o_tx.last) |-> (o_tx.data == req_q.opcode))
        else $error("opcode is not the first byte");

    a_addr_follows: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        s_opcode_sent |=> (o_tx_valid && o_tx.last && (o_tx.data == req_q.addr)))
        else $error("address does not follow the opcode");

    a_gap_long_enough: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        ((st_q == ccbc_pkg::ST_SEND2) && (cnt_q == 5'h00)) |-> (quiet_q >= LIM_EARLY))
        else $error("part two started inside the least frame delay");

    a_part_two_len: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (tx_fire && o_tx.last && (st_q == ccbc_pkg::ST_SEND2)) |-> ((cnt_q + 5'h01) == part2_len))
        else $error("part two length wrong");

    a_wait_bounded: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (waiting && (rcnt_q == 5'h00)) |-> (tmr_q <= lim))
        else $error("answer wait ran past its limit");

    a_value_silent_ok: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        s_value_silent |=> (o_done && (o_result == ccbc_pkg::RES_OK)))
        else $error("silent value part two not reported as success");

    a_done_when_idle: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        o_done |-> (o_req_ready && !o_tx_valid))
        else $error("done raised while a command is still running");
endmodule

//--- bench/ccbc_card_model.sv
// behavioural card answering reader frames
`timescale 1ns/100ps
module ccbc_card_model (
    input wire logic i_clk_sys, // clock
    input wire logic i_mute, // card silent
    input wire logic i_tx_valid, // reader byte
    input wire ccbc_pkg::ccbc_tx_t i_tx, // byte, last
    output logic o_tx_ready, // always ready
    output logic o_rx_valid, // answer item
    output ccbc_pkg::ccbc_rx_t o_rx // byte or code
);
    // ========
    // answers
    logic [7:0] f[$];
    logic authed = 1'b0;
    // answer after the least frame delay
    task automatic say(input int n, input logic nib, input logic [7:0] d);
        repeat (40) @(negedge i_clk_sys);
        for (int k = 0; k < n; k++) begin
            o_rx_valid = 1'b1;
            o_rx = {d, nib, k == n - 1};
            @(negedge i_clk_sys);
        end
        o_rx_valid = 1'b0;
        // released line shows no stale data
        o_rx = ~o_rx;
    endtask
    task automatic answer();
        // value part two gets no answer
        if (f.size() == 4) return;
        if (f.size() == 8 || f[0][7:1] == 7'h30) begin
            authed = 1'b1;
            say(4, 1'b0, 8'h5a);
        end
        else if (f.size() == 16) say(1, 1'b1, 8'h0a);
        // nak without auth or on an opcode c0h-c3h to block 07h
        else if (!authed || (f[0][7:2] == 6'h30 && f[1] == 8'h07)) say(1, 1'b1, 8'h04);
        else if (f[0] == 8'h30) say(16, 1'b0, f[1]);
        else say(1, 1'b1, 8'h0a);
    endtask
    initial begin
        o_tx_ready = 1'b1;
        o_rx_valid = 1'b0;
        o_rx = '0;
        forever begin
            @(posedge i_clk_sys);
            if (i_tx_valid && i_tx.last) begin
                f.push_back(i_tx.data);
                if (!i_mute) answer();
                f.delete();
            end else if (i_tx_valid) f.push_back(i_tx.data);
        end
    end
endmodule

//--- bench/tb_top.sv
// self-checking bench for the reader sequencer
`timescale 1ns/100ps
module tb_top;
    logic i_clk_sys = 1'b0;
    logic i_srst = 1'b1;
    logic i_req_valid = 1'b0;
    logic mute = 1'b0;
    logic o_req_ready, o_tx_valid, i_tx_ready, i_rx_valid, o_done;
    logic [127:0] o_rdata;
    ccbc_pkg::ccbc_req_t i_req = '0;
    ccbc_pkg::ccbc_tx_t o_tx;
    ccbc_pkg::ccbc_rx_t i_rx;
    ccbc_pkg::ccbc_res_t o_result;
    int err_total = 0;
    int compares = 0;
    always #10 i_clk_sys = ~i_clk_sys;
    // ========
    // short timeouts keep the run brief
    ccbc_reader #(.AUTH_TIMEOUT_CYC(400), .SHORT_TIMEOUT_CYC(600),
        .LONG_TIMEOUT_CYC(800), .FDT_MIN_CYC(20)) dut (.i_clk_sys, .i_srst,
        .i_req_valid, .i_req, .o_req_ready, .o_tx_valid, .o_tx, .i_tx_ready,
        .i_rx_valid, .i_rx, .o_done, .o_result, .o_rdata);
    ccbc_card_model c (.i_clk_sys, .i_mute(mute), .i_tx_valid(o_tx_valid), .i_tx(o_tx),
        .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid), .o_rx(i_rx));
    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic run(input logic [7:0] op, input logic [7:0] ad, input logic [2:0] r);
        int n = 0;
        @(negedge i_clk_sys);
        i_req_valid = 1'b1;
        i_req = {op, ad, {16{ad}}};
        @(posedge i_clk_sys);
        while (o_req_ready !== 1'b1) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_req_valid = 1'b0;
        while (o_done !== 1'b1 && n < 5000) begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        chk("done", 128'h1, {127'h0, o_done});
        chk("result", {125'h0, r}, {125'h0, o_result});
    endtask
    task automatic t_auth();
        run(8'h30, 8'h01, 3'h1);
        run(8'h60, 8'h00, 3'h0);
        run(8'h61, 8'h3f, 3'h0);
    endtask
    task automatic t_read();
        run(8'h30, 8'hff, 3'h0);
        chk("rdata", {16{8'hff}}, o_rdata);
        mute = 1'b1;
        run(8'h30, 8'h02, 3'h2);
        mute = 1'b0;
    endtask
    task automatic t_value();
        run(8'ha0, 8'h04, 3'h0);
        run(8'hc1, 8'h05, 3'h0);
        run(8'hc0, 8'h05, 3'h0);
        run(8'hc2, 8'h05, 3'h0);
        run(8'hc1, 8'h07, 3'h1);
        run(8'hb0, 8'h06, 3'h0);
    endtask
    task automatic print_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_srst = 1'b0;
        t_auth();
        t_read();
        t_value();
        print_verdict();
    end
    initial begin
        #1000000;
        err_total++;
        print_verdict();
    end
endmodule
